//--- common/abgl_defines.vh
// register offsets, field positions, reset values and limits of the
// amplifier boost, gain and limiter configuration bank
// assumes byte-wide registers reached through the two-wire serial port
`ifndef ABGL_DEFINES_VH
`define ABGL_DEFINES_VH

`define ABGL_ADDR_ID          8'h00
`define ABGL_ADDR_BST_OUT     8'h03
`define ABGL_ADDR_BST_ILIM    8'h04
`define ABGL_ADDR_GAIN        8'h05
`define ABGL_ADDR_LIM3_PWR    8'h06
`define ABGL_ADDR_LIM3_TIME   8'h07
`define ABGL_ADDR_LIM2_PWR    8'h08

`define ABGL_DEV_ADDR_HI      5'h16
`define ABGL_SOFT_RESET_KEY   8'hAA
// identification value is arbitrary, it names no real part
`define ABGL_ID_VALUE         8'h3C

`define ABGL_FORCE_BOOST_BIT  5
`define ABGL_VOUT_MSB         4
`define ABGL_VOUT_LSB         0
`define ABGL_IPEAK_MSB        4
`define ABGL_IPEAK_LSB        2
`define ABGL_GAIN_MSB         4
`define ABGL_GAIN_LSB         0
`define ABGL_LIM3_DIS_BIT     4
`define ABGL_LIM3_PWR_MSB     3
`define ABGL_LIM3_PWR_LSB     0
`define ABGL_LIM3_REL_MSB     7
`define ABGL_LIM3_REL_LSB     5
`define ABGL_LIM3_ATK_MSB     4
`define ABGL_LIM3_ATK_LSB     2
`define ABGL_LIM2_PWR_MSB     3
`define ABGL_LIM2_PWR_LSB     0

`define ABGL_RST_FORCE_BOOST  1'h1
`define ABGL_RST_VOUT         5'h10
`define ABGL_MAX_VOUT         5'h10
`define ABGL_RST_IPEAK        3'h4
`define ABGL_RST_GAIN_RCV     5'h05
`define ABGL_MIN_GAIN_RCV     5'h05
`define ABGL_MAX_GAIN_RCV     5'h07
`define ABGL_RST_GAIN_SPK     5'h10
`define ABGL_MIN_GAIN_SPK     5'h08
`define ABGL_MAX_GAIN_SPK     5'h12
`define ABGL_RST_LIM3_DIS     1'h0
`define ABGL_RST_LIM3_PWR     4'h3
`define ABGL_RST_LIM3_REL     3'h2
`define ABGL_BAD_LIM3_REL     3'h7
`define ABGL_RST_LIM3_ATK     3'h3
`define ABGL_RST_LIM2_PWR     4'h3
`define ABGL_MAX_LIM2_PWR     4'hB

`define ABGL_RSV_BST_OUT      2'h3
`define ABGL_RSV_ILIM_HI      3'h0
`define ABGL_RSV_ILIM_LO      2'h1
`define ABGL_RSV_GAIN         3'h0
`define ABGL_RSV_LIM3_PWR     3'h2
`define ABGL_RSV_LIM3_TIME    2'h2
`define ABGL_RSV_LIM2_PWR     4'h0

`endif

//--- hw/abgl_serial_port.v
// two-wire serial slave: address match, register pointer, byte
// writes and auto-incrementing reads toward the configuration bank
// assumes the clock oversamples the serial clock by at least 8x
`timescale 1ns/1ps
`include "abgl_defines.vh"

module abgl_serial_port (
	input  wire       sys_clk,     // system clock
	input  wire       rst_b,       // async reset, active low
	input  wire       scl_in,      // serial clock pin
	input  wire       sda_in,      // serial data pin level
	output reg        sda_oe,      // high while pulling data low
	input  wire [1:0] addr_sel,    // strapped low address bits
	output reg        wr_pulse,    // one-cycle write strobe
	output reg  [7:0] wr_data,     // write byte
	output reg  [7:0] ptr,         // register pointer
	input  wire [7:0] rd_data      // byte at pointer
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_PTR  = 3'h2;
	localparam ST_WDAT = 3'h3;
	localparam ST_RDAT = 3'h4;

	reg [2:0] scl_sync;
	reg [2:0] sda_sync;
	reg       scl_f;
	reg       sda_f;
	reg       scl_prev;
	reg       sda_prev;
	reg [2:0] state;
	reg [3:0] cnt;
	reg [7:0] shift;
	reg [7:0] tx;
	reg       ack_phase;
	reg       rw;

	wire start = scl_f & scl_prev & sda_prev & ~sda_f;
	wire stop  = scl_f & scl_prev & ~sda_prev & sda_f;
	wire rise  = scl_f & ~scl_prev;
	wire fall  = ~scl_f & scl_prev;

	// filtered level moves only when the last two stages agree
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			scl_f    <= 1'h1;
			sda_f    <= 1'h1;
			scl_prev <= 1'h1;
			sda_prev <= 1'h1;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
			if (scl_sync[1] == scl_sync[2])
				scl_f <= scl_sync[2];
			if (sda_sync[1] == sda_sync[2])
				sda_f <= sda_sync[2];
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= ST_IDLE;
			cnt       <= 4'h0;
			shift     <= 8'h00;
			tx        <= 8'h00;
			ack_phase <= 1'h0;
			rw        <= 1'h0;
			sda_oe    <= 1'h0;
			wr_pulse  <= 1'h0;
			wr_data   <= 8'h00;
			ptr       <= 8'h00;
		end else begin
			wr_pulse <= 1'h0;
			if (start) begin
				state     <= ST_ADDR;
				cnt       <= 4'h0;
				ack_phase <= 1'h0;
				sda_oe    <= 1'h0;
			end else if (stop) begin
				state  <= ST_IDLE;
				sda_oe <= 1'h0;
			end else begin
				case (state)
				ST_ADDR, ST_PTR, ST_WDAT: begin
					if (rise && !ack_phase) begin
						shift <= {shift[6:0], sda_f};
						cnt   <= cnt + 4'h1;
					end else if (fall && ack_phase) begin
						sda_oe    <= 1'h0;
						ack_phase <= 1'h0;
						cnt       <= 4'h0;
						if (state == ST_ADDR && rw) begin
							state  <= ST_RDAT;
							sda_oe <= ~rd_data[7];
							tx     <= {rd_data[6:0], 1'h0};
						end else if (state == ST_ADDR)
							state <= ST_PTR;
						else if (state == ST_PTR)
							state <= ST_WDAT;
						else
							ptr <= ptr + 8'h01; // burst moves on
					end else if (fall && cnt == 4'h8) begin
						ack_phase <= 1'h1;
						sda_oe    <= 1'h1;
						if (state == ST_ADDR) begin
							rw <= shift[0];
							if (shift[7:1] !=
							    {`ABGL_DEV_ADDR_HI, addr_sel}) begin
								state     <= ST_IDLE;
								ack_phase <= 1'h0;
								sda_oe    <= 1'h0;
							end
						end else if (state == ST_PTR)
							ptr <= shift;
						else begin
							wr_pulse <= 1'h1;
							wr_data  <= shift;
						end
					end
				end
				ST_RDAT: begin
					if (rise) begin
						if (cnt == 4'h8) begin
							// master nack ends the read burst
							if (sda_f)
								state <= ST_IDLE;
							else begin
								ptr <= ptr + 8'h01;
								cnt <= 4'h9;
							end
						end else
							cnt <= cnt + 4'h1;
					end else if (fall) begin
						if (cnt == 4'h8)
							sda_oe <= 1'h0;
						else if (cnt == 4'h9) begin
							sda_oe <= ~rd_data[7];
							tx     <= {rd_data[6:0], 1'h0};
							cnt    <= 4'h0;
						end else if (cnt != 4'h0) begin
							sda_oe <= ~tx[7];
							tx     <= {tx[6:0], 1'h0};
						end
					end
				end
				default: begin
					sda_oe <= 1'h0;
				end
				endcase
			end
		end
	end
endmodule

//--- hw/abgl_regs.v
// boost, gain and limiter configuration bank behind the serial port
// assumes the combo mode level comes from system control logic on sys_clk
`timescale 1ns/1ps
`include "abgl_defines.vh"

// What this block does
// - boost bit 5: 0 battery pass-through, 1 forced boost; resets 1
// - boost voltage code 6.5V to 10.5V, resets 10000, above refused
// - boost peak current code in bits 4:2, 2.5A to 4.25A, resets 100
// - combo mode gain accepts 00101 to 00111 only, resets 00101
// - speaker gain accepts 01000 to 10010, resets 10000
// - limiter3 disable bit 4 resets 0; power cap bits 3:0 reset 0011
// - limiter3 release rate bits 7:5, code 111 refused, resets 010
// - limiter3 attack rate bits 4:2, all codes legal, resets 011
// - limiter2 power bits 3:0, 1011 is off, above refused, resets 0011
// - combo select chooses gain coding and gain reset value
// - forced boost at 0 clears the battery safeguard software enable
// - serial address is 10110 plus two strapped bits, then read/write
// - writing AA to the identification register restores all defaults
module abgl_regs (
	input  wire       sys_clk,               // 100 MHz system clock
	input  wire       rst_b,                 // async reset, active low
	input  wire       scl_in,                // serial clock pin
	input  wire       sda_in,                // serial data pin level
	output wire       sda_out,               // data pin drive value
	output wire       sda_oe,                // data pin pull-down enable
	input  wire [1:0] addr_sel,              // strapped address bits
	input  wire       receiver_combo_select, // system control combo bit
	output reg        force_boost,           // 1 forces boost regulation
	output reg  [4:0] boost_voltage_code,    // boost output voltage
	output reg  [2:0] boost_peak_limit_code, // boost peak current
	output reg  [4:0] gain_code,             // class D gain
	output reg        limiter3_disable,      // limiter3 off when high
	output reg  [3:0] limiter3_power_level,  // limiter3 power cap
	output reg  [2:0] limiter3_release_rate, // limiter3 release
	output reg  [2:0] limiter3_attack_rate,  // limiter3 attack
	output reg  [3:0] limiter2_power_level,  // limiter2 power cap
	output reg        battery_safeguard_clear, // holds safeguard enable 0
	output reg        soft_reset_pulse       // one cycle on key write
);
	wire       wr_pulse;
	wire [7:0] wr_data;
	wire [7:0] ptr;
	reg  [7:0] rd_data;
	reg        init_done_reg;
	reg        gain_ok;

	wire soft_rst = wr_pulse && ptr == `ABGL_ADDR_ID &&
	                wr_data == `ABGL_SOFT_RESET_KEY;
	wire [4:0] gain_default = receiver_combo_select ?
	                          `ABGL_RST_GAIN_RCV : `ABGL_RST_GAIN_SPK;

	assign sda_out = 1'b0;

	abgl_serial_port u_port (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_oe   (sda_oe),
		.addr_sel (addr_sel),
		.wr_pulse (wr_pulse),
		.wr_data  (wr_data),
		.ptr      (ptr),
		.rd_data  (rd_data)
	);

	// gain legality follows the coding of the current mode
	always @* begin
		if (receiver_combo_select)
			gain_ok = wr_data[4:0] >= `ABGL_MIN_GAIN_RCV &&
			          wr_data[4:0] <= `ABGL_MAX_GAIN_RCV;
		else
			gain_ok = wr_data[4:0] >= `ABGL_MIN_GAIN_SPK &&
			          wr_data[4:0] <= `ABGL_MAX_GAIN_SPK;
	end

	// async reset may only load constants, so the mode-dependent gain
	// default is applied on the first clock after release
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			init_done_reg         <= 1'h0;
			force_boost           <= `ABGL_RST_FORCE_BOOST;
			boost_voltage_code    <= `ABGL_RST_VOUT;
			boost_peak_limit_code <= `ABGL_RST_IPEAK;
			gain_code             <= `ABGL_RST_GAIN_SPK;
			limiter3_disable      <= `ABGL_RST_LIM3_DIS;
			limiter3_power_level  <= `ABGL_RST_LIM3_PWR;
			limiter3_release_rate <= `ABGL_RST_LIM3_REL;
			limiter3_attack_rate  <= `ABGL_RST_LIM3_ATK;
			limiter2_power_level  <= `ABGL_RST_LIM2_PWR;
			soft_reset_pulse      <= 1'h0;
		end else begin
			init_done_reg    <= 1'h1;
			soft_reset_pulse <= soft_rst;
			if (!init_done_reg)
				gain_code <= gain_default;
			if (soft_rst) begin
				force_boost           <= `ABGL_RST_FORCE_BOOST;
				boost_voltage_code    <= `ABGL_RST_VOUT;
				boost_peak_limit_code <= `ABGL_RST_IPEAK;
				gain_code             <= gain_default;
				limiter3_disable      <= `ABGL_RST_LIM3_DIS;
				limiter3_power_level  <= `ABGL_RST_LIM3_PWR;
				limiter3_release_rate <= `ABGL_RST_LIM3_REL;
				limiter3_attack_rate  <= `ABGL_RST_LIM3_ATK;
				limiter2_power_level  <= `ABGL_RST_LIM2_PWR;
			end else if (wr_pulse) begin
				// reserved bits are never stored
				case (ptr)
				`ABGL_ADDR_BST_OUT: begin
					force_boost <= wr_data[`ABGL_FORCE_BOOST_BIT];
					// out-of-range voltage code keeps the old one
					if (wr_data[`ABGL_VOUT_MSB:`ABGL_VOUT_LSB] <=
					    `ABGL_MAX_VOUT)
						boost_voltage_code <=
						  wr_data[`ABGL_VOUT_MSB:`ABGL_VOUT_LSB];
				end
				`ABGL_ADDR_BST_ILIM: begin
					boost_peak_limit_code <=
					  wr_data[`ABGL_IPEAK_MSB:`ABGL_IPEAK_LSB];
				end
				`ABGL_ADDR_GAIN: begin
					if (gain_ok)
						gain_code <=
						  wr_data[`ABGL_GAIN_MSB:`ABGL_GAIN_LSB];
				end
				`ABGL_ADDR_LIM3_PWR: begin
					limiter3_disable <= wr_data[`ABGL_LIM3_DIS_BIT];
					limiter3_power_level <=
					  wr_data[`ABGL_LIM3_PWR_MSB:`ABGL_LIM3_PWR_LSB];
				end
				`ABGL_ADDR_LIM3_TIME: begin
					if (wr_data[`ABGL_LIM3_REL_MSB:`ABGL_LIM3_REL_LSB] !=
					    `ABGL_BAD_LIM3_REL)
						limiter3_release_rate <=
						  wr_data[`ABGL_LIM3_REL_MSB:`ABGL_LIM3_REL_LSB];
					limiter3_attack_rate <=
					  wr_data[`ABGL_LIM3_ATK_MSB:`ABGL_LIM3_ATK_LSB];
				end
				`ABGL_ADDR_LIM2_PWR: begin
					// code 1011 is legal and switches limiter2 off
					if (wr_data[`ABGL_LIM2_PWR_MSB:`ABGL_LIM2_PWR_LSB] <=
					    `ABGL_MAX_LIM2_PWR)
						limiter2_power_level <=
						  wr_data[`ABGL_LIM2_PWR_MSB:`ABGL_LIM2_PWR_LSB];
				end
				default: begin
				end
				endcase
			end
		end
	end

	// the safeguard enable lives in system control; this level holds it 0
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			battery_safeguard_clear <= 1'h0;
		else
			battery_safeguard_clear <= ~force_boost;
	end

	// read view, reserved bits show their defaults
	always @* begin
		case (ptr)
		`ABGL_ADDR_ID:        rd_data = `ABGL_ID_VALUE;
		`ABGL_ADDR_BST_OUT:   rd_data = {`ABGL_RSV_BST_OUT, force_boost,
		                                 boost_voltage_code};
		`ABGL_ADDR_BST_ILIM:  rd_data = {`ABGL_RSV_ILIM_HI,
		                                 boost_peak_limit_code,
		                                 `ABGL_RSV_ILIM_LO};
		`ABGL_ADDR_GAIN:      rd_data = {`ABGL_RSV_GAIN, gain_code};
		`ABGL_ADDR_LIM3_PWR:  rd_data = {`ABGL_RSV_LIM3_PWR, limiter3_disable,
		                                 limiter3_power_level};
		`ABGL_ADDR_LIM3_TIME: rd_data = {limiter3_release_rate,
		                                 limiter3_attack_rate,
		                                 `ABGL_RSV_LIM3_TIME};
		`ABGL_ADDR_LIM2_PWR:  rd_data = {`ABGL_RSV_LIM2_PWR,
		                                 limiter2_power_level};
		default:              rd_data = 8'h00;
		endcase
	end
endmodule

//--- testbench/abgl_checker.sv
// checker for the boost, gain and limiter bank, sees only its ports
// assumes one clock domain with an active-low async reset
`timescale 1ns/1ps
module abgl_checker (
	input logic       sys_clk,
	input logic       rst_b,
	input logic       scl_in,
	input logic       sda_in,
	input logic       sda_out,
	input logic       sda_oe,
	input logic [1:0] addr_sel,
	input logic       receiver_combo_select,
	input logic       force_boost,
	input logic [4:0] boost_voltage_code,
	input logic [2:0] boost_peak_limit_code,
	input logic [4:0] gain_code,
	input logic       limiter3_disable,
	input logic [3:0] limiter3_power_level,
	input logic [2:0] limiter3_release_rate,
	input logic [2:0] limiter3_attack_rate,
	input logic [3:0] limiter2_power_level,
	input logic       battery_safeguard_clear,
	input logic       soft_reset_pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	safeguard_follow_a: assert property (
		battery_safeguard_clear == !$past(force_boost))
		else $error("safeguard clear does not follow forced boost");
	vout_range_a: assert property (
		boost_voltage_code <= 5'h10)
		else $error("boost voltage code above limit");
	gain_range_a: assert property (
		$changed(gain_code) && $past(rst_b) |->
		($past(receiver_combo_select) ?
		 (gain_code inside {[5'h05:5'h07]}) :
		 (gain_code inside {[5'h08:5'h12]})))
		else $error("gain took a code outside the mode range");
	release_legal_a: assert property (
		limiter3_release_rate != 3'h7)
		else $error("release rate holds unavailable code");
	lim2_range_a: assert property (
		limiter2_power_level <= 4'hB)
		else $error("limiter2 power above off code");
	soft_defaults_a: assert property (
		soft_reset_pulse |-> ##[0:2] (force_boost &&
		boost_voltage_code == 5'h10 && limiter2_power_level == 4'h3 &&
		limiter3_release_rate == 3'h2))
		else $error("soft reset did not restore defaults");
	reset_values_a: assert property (
		$rose(rst_b) |-> force_boost && boost_voltage_code == 5'h10 &&
		boost_peak_limit_code == 3'h4 && !limiter3_disable &&
		limiter3_power_level == 4'h3 && limiter3_attack_rate == 3'h3)
		else $error("field not at reset value");
	gain_default_a: assert property (
		$rose(rst_b) |=> gain_code ==
		($past(receiver_combo_select) ? 5'h05 : 5'h10))
		else $error("gain default does not match mode");
	sda_timing_a: assert property (
		$changed(sda_oe) |-> !scl_in)
		else $error("data line moved while serial clock high");

	cover property (soft_reset_pulse);
	cover property ($rose(sda_oe));
	cover property (receiver_combo_select && $changed(gain_code));
endmodule

bind abgl_regs abgl_checker i_chk (.sys_clk, .rst_b, .scl_in, .sda_in,
	.sda_out, .sda_oe, .addr_sel, .receiver_combo_select, .force_boost,
	.boost_voltage_code, .boost_peak_limit_code, .gain_code,
	.limiter3_disable, .limiter3_power_level, .limiter3_release_rate,
	.limiter3_attack_rate, .limiter2_power_level,
	.battery_safeguard_clear, .soft_reset_pulse);

//--- testbench/abgl_i2c_host.sv
// two-wire host model: open-drain data, clock made only within frames
// assumes the wire is pulled high and resolved by the bench
`timescale 1ns/1ps
module abgl_i2c_host (
	input  wire sys_clk,  // system clock, paces the serial bits
	input  wire sda_line, // resolved data wire level
	output reg  scl,      // serial clock, high when idle
	output reg  sda_oe    // high while pulling data low
);
	reg r;
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// quarter bit of 10 clocks keeps well inside the 8x oversampling
	task q;
		repeat (10) @(negedge sys_clk);
	endtask
	task start;
		sda_oe = 1'b0;
		q;
		scl = 1'b1;
		q;
		sda_oe = 1'b1;
		q;
		scl = 1'b0;
		q;
	endtask
	task stop;
		sda_oe = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_oe = 1'b0;
		q;
	endtask
	task bit_o(input b, output s);
		sda_oe = ~b;
		q;
		scl = 1'b1;
		q;
		s = sda_line;
		q;
		scl = 1'b0;
		q;
	endtask
	task wbyte(input [7:0] v, output ack);
		integer i;
		for (i = 7; i >= 0; i = i - 1) bit_o(v[i], r);
		bit_o(1'b1, r);
		ack = ~r;
	endtask
	task wr(input [6:0] dev, input [7:0] a, input [7:0] v, output ok);
		reg a0, a1, a2;
		start;
		wbyte({dev, 1'b0}, a0);
		wbyte(a, a1);
		wbyte(v, a2);
		stop;
		ok = a0 & a1 & a2;
	endtask
	task wr2(input [6:0] dev, input [7:0] a, input [7:0] v0,
	         input [7:0] v1);
		start;
		wbyte({dev, 1'b0}, r);
		wbyte(a, r);
		wbyte(v0, r);
		wbyte(v1, r);
		stop;
	endtask
	task rd(input [6:0] dev, input [7:0] a, output [7:0] v);
		integer i;
		start;
		wbyte({dev, 1'b0}, r);
		wbyte(a, r);
		start;
		wbyte({dev, 1'b1}, r);
		for (i = 7; i >= 0; i = i - 1) bit_o(1'b1, v[i]);
		bit_o(1'b1, r);
		stop;
	endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the boost, gain and limiter bank
// assumes the host model drives the serial port, strap tied to 2'b10
`timescale 1ns/1ps
module tb;
	reg        sys_clk = 1'b0;
	reg        rst_b = 1'b0;
	reg        combo = 1'b0;
	reg        seen = 1'b0;
	reg        ok;
	reg  [7:0] d;
	wire       scl, h_oe, sda_oe, fb, l3d, sgc, srp, sdo;
	wire [4:0] vout, gain;
	wire [2:0] ipk, rel, atk;
	wire [3:0] l3p, l2p;
	wire       sda_line = ~(h_oe | sda_oe);
	integer    n_errors = 0;
	integer    n_tests = 0;
	localparam [6:0] DEV = 7'h5A;

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (srp) seen <= 1'b1;

	abgl_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sdo), .sda_oe(sda_oe),
		.addr_sel(2'h2), .receiver_combo_select(combo),
		.force_boost(fb), .boost_voltage_code(vout),
		.boost_peak_limit_code(ipk), .gain_code(gain),
		.limiter3_disable(l3d), .limiter3_power_level(l3p),
		.limiter3_release_rate(rel), .limiter3_attack_rate(atk),
		.limiter2_power_level(l2p), .battery_safeguard_clear(sgc),
		.soft_reset_pulse(srp));
	abgl_i2c_host i_host (.sys_clk(sys_clk), .sda_line(sda_line),
		.scl(scl), .sda_oe(h_oe));

	task chk(input [8*12:1] nm, input [7:0] e, input [7:0] g);
		n_tests = n_tests + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("wrong value %0s exp %h got %h", nm, e, g);
		end
	endtask
	task rchk(input [7:0] a, input [7:0] e);
		i_host.rd(DEV, a, d);
		chk("register", e, d);
	endtask
	task wr(input [7:0] a, input [7:0] v);
		i_host.wr(DEV, a, v, ok);
		chk("ack", 8'h01, {7'h0, ok});
	endtask
	task finish_test;
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task t_reset;
		rchk(8'h03, 8'hF0);
		rchk(8'h04, 8'h11);
		rchk(8'h05, 8'h10);
		rchk(8'h06, 8'h43);
		rchk(8'h07, 8'h4E);
		rchk(8'h08, 8'h03);
		chk("safeguard", 8'h00, {7'h0, sgc});
		chk("data drive", 8'h00, {7'h0, sdo});
		$display("test reset done");
	endtask
	task t_fields;
		wr(8'h03, 8'h00);
		rchk(8'h03, 8'hC0);
		chk("boost force", 8'h00, {7'h0, fb});
		chk("safeguard", 8'h01, {7'h0, sgc});
		wr(8'h03, 8'hFF);
		rchk(8'h03, 8'hE0);
		chk("voltage", 8'h00, {3'h0, vout});
		wr(8'h04, 8'hFF);
		rchk(8'h04, 8'h1D);
		chk("peak limit", 8'h07, {5'h0, ipk});
		wr(8'h06, 8'h1F);
		rchk(8'h06, 8'h5F);
		chk("limiter3 pwr", 8'h1F, {3'h0, l3d, l3p});
		wr(8'h07, 8'hFF);
		rchk(8'h07, 8'h5E);
		chk("limiter3 tim", 8'h17, {2'h0, rel, atk});
		wr(8'h08, 8'h0B);
		rchk(8'h08, 8'h0B);
		chk("limiter2 pwr", 8'h0B, {4'h0, l2p});
		wr(8'h08, 8'h0C);
		rchk(8'h08, 8'h0B);
		$display("test fields done");
	endtask
	task t_gain;
		wr(8'h05, 8'h12);
		rchk(8'h05, 8'h12);
		wr(8'h05, 8'h13);
		rchk(8'h05, 8'h12);
		wr(8'h05, 8'h07);
		rchk(8'h05, 8'h12);
		@(negedge sys_clk) combo = 1'b1;
		wr(8'h05, 8'h06);
		rchk(8'h05, 8'h06);
		wr(8'h05, 8'h04);
		rchk(8'h05, 8'h06);
		wr(8'h05, 8'h08);
		rchk(8'h05, 8'h06);
		chk("gain port", 8'h06, {3'h0, gain});
		$display("test gain done");
	endtask
	task t_soft;
		seen = 1'b0;
		wr(8'h00, 8'hAA);
		chk("soft pulse", 8'h01, {7'h0, seen});
		rchk(8'h05, 8'h05);
		rchk(8'h03, 8'hF0);
		rchk(8'h08, 8'h03);
		$display("test soft reset done");
	endtask
	task t_addr;
		i_host.wr(7'h58, 8'h08, 8'h05, ok);
		chk("foreign ack", 8'h00, {7'h0, ok});
		rchk(8'h08, 8'h03);
		$display("test address done");
	endtask
	task t_burst;
		i_host.wr2(DEV, 8'h07, 8'h20, 8'h05);
		rchk(8'h07, 8'h22);
		rchk(8'h08, 8'h05);
		chk("limiter2 pwr", 8'h05, {4'h0, l2p});
		$display("test burst done");
	endtask
	task t_reset_combo;
		@(negedge sys_clk) rst_b = 1'b0;
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (10) @(negedge sys_clk);
		rchk(8'h05, 8'h05);
		rchk(8'h08, 8'h03);
		chk("gain port", 8'h05, {3'h0, gain});
		$display("test combo reset done");
	endtask

	initial begin
		#1000000;
		n_errors = n_errors + 1;
		finish_test;
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (10) @(negedge sys_clk);
		t_reset;
		t_fields;
		t_gain;
		t_soft;
		t_addr;
		t_burst;
		t_reset_combo;
		finish_test;
	end
endmodule
